// ===== verilog/tcmc_consts.svh
// constants of the timer channel mode and control block
`ifndef TCMC_CONSTS_SVH
`define TCMC_CONSTS_SVH
`define TCMC_OFF_SC       8'h00
`define TCMC_OFF_VALUE    8'h04
`define TCMC_OFF_GCTRL    8'h08
`define TCMC_OFF_IRQ_STAT 8'h0C
`define TCMC_OFF_IRQ_MASK 8'h10
`define TCMC_OFF_COUNTER  8'h14
`define TCMC_ADDR_W       8
`define TCMC_BIT_FLAG     7
`define TCMC_BIT_IE       6
`define TCMC_BIT_MSH      5
`define TCMC_BIT_MSL      4
`define TCMC_BIT_ELSH     3
`define TCMC_BIT_ELSL     2
`define TCMC_BIT_CENTER   0
`define TCMC_EV_CHAN      0
`define TCMC_EV_MATCH     1
`define TCMC_EV_W         2
`define TCMC_ELS_OFF      2'h0
`define TCMC_ELS_01       2'h1
`define TCMC_ELS_10       2'h2
`define TCMC_ELS_11       2'h3
`define TCMC_VALUE_RST    16'h0000
`define TCMC_ZERO16       16'h0000
`define TCMC_ZERO32       32'h0000_0000
`endif

// ===== verilog/tcmc_pkg.sv
// types of the timer channel mode and control block
package tcmc_pkg;
   typedef enum logic [3:0] {
      TCMC_MODE_IC   = 4'h1,
      TCMC_MODE_OC   = 4'h2,
      TCMC_MODE_EPWM = 4'h4,
      TCMC_MODE_CPWM = 4'h8
   } tcmc_mode_e;
   typedef logic [15:0] tcmc_word_t;
endpackage

// ===== verilog/tcmc_channel.sv
// timer channel mode, flag, pin and apb register logic
`include "tcmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tcmc_channel
   import tcmc_pkg::*;
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`TCMC_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [15:0]               counter_value,
   input  wire logic [15:0]               modulo_value,
   input  wire logic                      chan_pin_in,
   output logic                           chan_pin_out,
   output logic                           chan_pin_oe,
   output logic                           center_align_select,
   output logic                           chan_irq,
   output logic                           irq
);
   function automatic logic [7:0] merge_byte(
      input logic [7:0] old_v,
      input logic [7:0] new_v,
      input logic       en
   );
      merge_byte = en ? new_v : old_v;
   endfunction

   function automatic logic duty_extreme(
      input tcmc_word_t cv,
      input tcmc_word_t md
   );
      duty_extreme = (cv == `TCMC_ZERO16) ||
                     ((md != `TCMC_ZERO16) && (cv > md));
   endfunction

   logic                     flag_reg;
   logic                     ie_reg;
   logic                     msh_reg;
   logic                     msl_reg;
   logic [1:0]               els_reg;
   logic                     armed_reg;
   logic                     armed_next;
   logic                     flag_next;
   tcmc_word_t               value_reg;
   tcmc_word_t               value_next;
   logic                     center_reg;
   logic [`TCMC_EV_W-1:0]    stat_reg;
   logic [`TCMC_EV_W-1:0]    mask_reg;
   logic                     pin_meta_reg;
   logic                     pin_sync_reg;
   logic                     pin_prev_reg;
   logic                     match_prev_reg;
   logic                     pin_out_reg;
   logic                     pin_out_next;
   logic                     pin_oe_reg;
   logic                     chan_irq_reg;
   logic                     irq_reg;
   logic [31:0]              prdata_reg;
   logic                     pready_reg;
   logic                     pslverr_reg;

   // mode decode
   tcmc_mode_e               mode;
   assign mode = center_reg ? TCMC_MODE_CPWM :
                 msh_reg    ? TCMC_MODE_EPWM :
                 msl_reg    ? TCMC_MODE_OC   :
                              TCMC_MODE_IC;

   wire mode_ic  = (mode == TCMC_MODE_IC);
   wire mode_oc  = (mode == TCMC_MODE_OC);
   wire mode_pwm = (mode == TCMC_MODE_EPWM) ||
                   (mode == TCMC_MODE_CPWM);

   // apb decode
   wire acc_start = psel & penable & ~pready_reg;
   wire acc_done  = psel & penable & pready_reg;
   wire wr_done   = acc_done & pwrite;
   wire rd_done   = acc_done & ~pwrite;
   wire hit_sc    = (paddr == `TCMC_OFF_SC);
   wire hit_val   = (paddr == `TCMC_OFF_VALUE);
   wire hit_gctl  = (paddr == `TCMC_OFF_GCTRL);
   wire hit_stat  = (paddr == `TCMC_OFF_IRQ_STAT);
   wire hit_mask  = (paddr == `TCMC_OFF_IRQ_MASK);
   wire hit_cnt   = (paddr == `TCMC_OFF_COUNTER);
   wire hit_any   = hit_sc | hit_val | hit_gctl |
                    hit_stat | hit_mask | hit_cnt;
   wire wr_sc     = wr_done & hit_sc & pstrb[0];
   wire wr_val    = wr_done & hit_val & ~mode_ic;
   wire wr_gctl   = wr_done & hit_gctl & pstrb[0];
   wire wr_stat   = wr_done & hit_stat & pstrb[0];
   wire wr_mask   = wr_done & hit_mask & pstrb[0];

   // edge detection on synchronised samples
   wire pin_rise  = pin_sync_reg & ~pin_prev_reg;
   wire pin_fall  = ~pin_sync_reg & pin_prev_reg;
   wire edge_hit  = (els_reg == `TCMC_ELS_01) ? pin_rise :
                    (els_reg == `TCMC_ELS_10) ? pin_fall :
                    (els_reg == `TCMC_ELS_11) ?
                    (pin_rise | pin_fall) : 1'b0;
   wire ic_event  = mode_ic & edge_hit;

   // compare match on the rising edge of equality
   wire match_now = (counter_value == value_reg);
   wire match_rise = match_now & ~match_prev_reg;
   wire extreme   = duty_extreme(value_reg, modulo_value);
   wire cmp_event = match_rise & (mode_oc |
                    (mode_pwm & ~extreme));
   wire chan_event = ic_event | cmp_event;

   // flag clear sequence
   wire sc_read_armed = rd_done & hit_sc & prdata_reg[`TCMC_BIT_FLAG];
   wire clear_ok  = wr_sc & armed_reg &
                    ~pwdata[`TCMC_BIT_FLAG];
   assign flag_next = chan_event ? 1'b1 :
                      clear_ok   ? 1'b0 :
                                   flag_reg;
   assign armed_next = chan_event ? 1'b0 :
                       wr_sc      ? 1'b0 :
                       sc_read_armed ? 1'b1 :
                                   armed_reg;

   // channel value: capture or compare
   wire [15:0] val_wr = {merge_byte(value_reg[15:8],
                                    pwdata[15:8], pstrb[1]),
                         merge_byte(value_reg[7:0],
                                    pwdata[7:0], pstrb[0])};
   assign value_next = ic_event ? counter_value :
                       wr_val   ? val_wr : value_reg;

   // pin level
   wire pwm_high = (counter_value < value_reg);
   always_comb
   begin
      pin_out_next = pin_out_reg;
      if (mode_pwm)
      begin
         if (els_reg == `TCMC_ELS_10)
            pin_out_next = pwm_high;
         else
            pin_out_next = ~pwm_high;
      end
      else if (mode_oc && match_rise)
      begin
         unique case (els_reg)
            `TCMC_ELS_01: pin_out_next = ~pin_out_reg;
            `TCMC_ELS_10: pin_out_next = 1'b0;
            `TCMC_ELS_11: pin_out_next = 1'b1;
            `TCMC_ELS_OFF: pin_out_next = pin_out_reg;
         endcase
      end
   end
   wire pin_oe_next = ~mode_ic &
                      (els_reg != `TCMC_ELS_OFF);

   // read mux
   wire [7:0] sc_rd = {flag_reg, ie_reg, msh_reg, msl_reg,
                       els_reg, 2'h0};
   wire [31:0] rd_mux =
      hit_sc   ? {24'h00_0000, sc_rd} :
      hit_val  ? {16'h0000, value_reg} :
      hit_gctl ? {31'h0000_0000, center_reg} :
      hit_stat ? {30'h0000_0000, stat_reg} :
      hit_mask ? {30'h0000_0000, mask_reg} :
      hit_cnt  ? {16'h0000, counter_value} : `TCMC_ZERO32;

   // interrupt status events
   wire [`TCMC_EV_W-1:0] ev_vec = {match_rise, chan_event};
   wire [`TCMC_EV_W-1:0] stat_next =
      ev_vec | (stat_reg & ~(wr_stat ?
      pwdata[`TCMC_EV_W-1:0] : 2'h0));

   // pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= chan_pin_in;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // channel status and control
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_reg  <= 1'b0;
         armed_reg <= 1'b0;
         ie_reg    <= 1'b0;
         msh_reg   <= 1'b0;
         msl_reg   <= 1'b0;
         els_reg   <= `TCMC_ELS_OFF;
      end
      else
      begin
         flag_reg  <= flag_next;
         armed_reg <= armed_next;
         if (wr_sc)
         begin
            ie_reg  <= pwdata[`TCMC_BIT_IE];
            msh_reg <= pwdata[`TCMC_BIT_MSH];
            msl_reg <= pwdata[`TCMC_BIT_MSL];
            els_reg <= pwdata[`TCMC_BIT_ELSH:`TCMC_BIT_ELSL];
         end
      end
   end

   // value, global control and interrupt registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         value_reg      <= `TCMC_VALUE_RST;
         center_reg     <= 1'b0;
         match_prev_reg <= 1'b0;
         stat_reg       <= 2'h0;
         mask_reg       <= 2'h0;
      end
      else
      begin
         value_reg      <= value_next;
         match_prev_reg <= match_now;
         stat_reg       <= stat_next;
         if (wr_gctl)
            center_reg <= pwdata[`TCMC_BIT_CENTER];
         if (wr_mask)
            mask_reg <= pwdata[`TCMC_EV_W-1:0];
      end
   end

   // registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_out_reg  <= 1'b0;
         pin_oe_reg   <= 1'b0;
         chan_irq_reg <= 1'b0;
         irq_reg      <= 1'b0;
      end
      else
      begin
         pin_out_reg  <= pin_out_next;
         pin_oe_reg   <= pin_oe_next;
         chan_irq_reg <= flag_next & ie_reg;
         irq_reg      <= |(stat_next & mask_reg);
      end
   end

   // apb answer: one wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= `TCMC_ZERO32;
      end
      else
      begin
         pready_reg  <= acc_start;
         pslverr_reg <= acc_start & ~hit_any;
         if (acc_start)
            prdata_reg <= pwrite ? `TCMC_ZERO32 : rd_mux;
      end
   end

   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign chan_pin_out        = pin_out_reg;
   assign chan_pin_oe         = pin_oe_reg;
   assign center_align_select = center_reg;
   assign chan_irq            = chan_irq_reg;
   assign irq                 = irq_reg;
endmodule
`default_nettype wire

// ===== sim/tcmc_channel_asserts.sv
// checker of channel pin, flag and interrupt behaviour
`include "tcmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tcmc_channel_asserts
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`TCMC_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [3:0]              pstrb,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic [15:0]             counter_value,
   input wire logic                    chan_pin_out,
   input wire logic                    chan_pin_oe,
   input wire logic                    center_align_select,
   input wire logic                    chan_irq
);
   logic [7:0]  sc_reg;
   logic [15:0] val_reg;
   logic        ca_reg;
   wire         wr  = psel & penable & pready & pwrite & pstrb[0];
   wire         ic  = !ca_reg && sc_reg[5:4] == 2'h0;
   wire         oc  = !ca_reg && sc_reg[5:4] == 2'h1;
   wire         pwm = ca_reg | sc_reg[5];
   wire         hit = counter_value == val_reg;
   wire         lvl = sc_reg[2] ^ (counter_value < val_reg);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sc_reg  <= 8'h00;
         val_reg <= 16'h0000;
         ca_reg  <= 1'b0;
      end
      else if (wr)
      begin
         if (paddr == `TCMC_OFF_SC)
            sc_reg <= pwdata[7:0];
         if (paddr == `TCMC_OFF_VALUE && !ic)
            val_reg <= pwdata[15:0];
         if (paddr == `TCMC_OFF_GCTRL)
            ca_reg <= pwdata[0];
      end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_match;
      oc && hit && !$past(hit);
   endsequence
   a_pin_released: assert property
      ((sc_reg[3:2] == 2'h0)[*2] |-> !chan_pin_oe)
      else $error("pin driven while released");
   a_irq_blocked: assert property ((!sc_reg[6])[*2] |-> !chan_irq)
      else $error("interrupt while disabled");
   a_irq_gate: assert property
      (pready && psel && !pwrite && paddr == `TCMC_OFF_SC &&
       $past(sc_reg[6], 2) |-> $past(chan_irq) == prdata[7])
      else $error("interrupt not following flag");
   a_center_copy: assert property
      (center_align_select == ca_reg)
      else $error("center align output wrong");
   a_oc_high: assert property
      (s_match ##0 sc_reg[3:2] == 2'h3 |=> chan_pin_out && chan_pin_oe)
      else $error("compare set failed");
   a_oc_low: assert property
      (s_match ##0 sc_reg[3:2] == 2'h2 |=> !chan_pin_out && chan_pin_oe)
      else $error("compare clear failed");
   a_oc_toggle: assert property
      (s_match ##0 sc_reg[3:2] == 2'h1 |=> chan_pin_out != $past(chan_pin_out))
      else $error("compare toggle failed");
   a_pwm_level: assert property
      (pwm && sc_reg[3:2] != 2'h0 |=> chan_pin_oe && chan_pin_out == $past(lvl))
      else $error("pwm level wrong");
   a_ic_undriven: assert property (ic |=> !chan_pin_oe)
      else $error("pin driven in capture");
endmodule
bind tcmc_channel tcmc_channel_asserts tcmc_channel_asserts_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .counter_value, .chan_pin_out, .chan_pin_oe, .center_align_select,
   .chan_irq);
`default_nettype wire

// ===== sim/tcmc_far_side.sv
// far side model: main counter and channel pin source
`timescale 1ns/10ps
`default_nettype none
module tcmc_far_side
(
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   run,
   input  wire logic   lvl,
   output logic [15:0] counter_value,
   output logic        chan_pin_in
);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         counter_value <= 16'h0000;
         chan_pin_in   <= 1'b0;
      end
      else
      begin
         counter_value <= counter_value + {15'h0000, run};
         chan_pin_in   <= lvl;
      end
endmodule
`default_nettype wire

// ===== sim/tcmc_channel_tb.sv
// self-checking bench of the timer channel block
`include "tcmc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tcmc_channel_tb;
   logic        pclk, presetn, psel, penable, pwrite, run, lvl, se, pready;
   logic        pslverr, chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq, irq;
   logic        center_align_select;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] counter_value, modulo_value;
   int          err_total, compares;
   tcmc_channel tcmc_channel_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .counter_value,
      .modulo_value, .chan_pin_in, .chan_pin_out, .chan_pin_oe,
      .center_align_select, .chan_irq, .irq);
   tcmc_far_side tcmc_far_side_i (.pclk, .presetn, .run, .lvl,
      .counter_value, .chan_pin_in);
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic tick(int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      do
      begin
         tick(1);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_total++;
         complete_run();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   task automatic t_reset;
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("sc reset", 32'h0, rd);
      chk("mapped", 32'h0, {31'h0, se});
      apb(1, `TCMC_OFF_SC, 32'h80);
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("flag write one", 32'h0, rd);
      apb(0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, se});
      chk("unmapped data", 32'h0, rd);
   endtask
   task automatic t_capture;
      logic [1:0] e;
      run <= 1'b1;
      tick(5);
      run <= 1'b0;
      for (int i = 1; i < 4; i++)
      begin
         e = i[1:0];
         apb(1, `TCMC_OFF_SC, {28'h0, e, 2'h0});
         lvl <= 1'b1;
         tick(8);
         apb(0, `TCMC_OFF_SC, 32'h0);
         chk("rise flag", {24'h0, e[0], 3'h0, e, 2'h0}, rd);
         apb(1, `TCMC_OFF_SC, {28'h0, e, 2'h0});
         lvl <= 1'b0;
         tick(8);
         apb(0, `TCMC_OFF_SC, 32'h0);
         chk("fall flag", {24'h0, e[1], 3'h0, e, 2'h0}, rd);
         apb(1, `TCMC_OFF_SC, {28'h0, e, 2'h0});
      end
      apb(0, `TCMC_OFF_VALUE, 32'h0);
      chk("capture value", 32'h5, rd);
      apb(1, `TCMC_OFF_VALUE, 32'h1234);
      apb(0, `TCMC_OFF_VALUE, 32'h0);
      chk("capture write ignored", 32'h5, rd);
   endtask
   task automatic t_clear;
      apb(1, `TCMC_OFF_IRQ_STAT, 32'h3);
      apb(1, `TCMC_OFF_IRQ_MASK, 32'h1);
      apb(1, `TCMC_OFF_SC, 32'h4C);
      chk("irq idle", 32'h0, {30'h0, chan_irq, irq});
      lvl <= 1'b1;
      tick(8);
      chk("irq set", 32'h3, {30'h0, chan_irq, irq});
      apb(1, `TCMC_OFF_IRQ_MASK, 32'h0);
      tick(1);
      chk("irq masked", 32'h2, {30'h0, chan_irq, irq});
      apb(1, `TCMC_OFF_IRQ_MASK, 32'h1);
      apb(1, `TCMC_OFF_SC, 32'h4C);
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("write unarmed", 32'hCC, rd);
      lvl <= 1'b0;
      tick(8);
      apb(1, `TCMC_OFF_SC, 32'h4C);
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("event after arm", 32'hCC, rd);
      apb(1, `TCMC_OFF_SC, 32'h4C);
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("flag cleared", 32'h4C, rd);
      apb(1, `TCMC_OFF_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'h0, {30'h0, chan_irq, irq});
   endtask
   task automatic arm(logic [7:0] sc, logic [15:0] md, logic f, logic [1:0] p);
      run <= 1'b0;
      modulo_value <= md;
      apb(1, `TCMC_OFF_SC, {24'h0, sc});
      apb(0, `TCMC_OFF_COUNTER, 32'h0);
      apb(1, `TCMC_OFF_VALUE, rd + 32'h4);
      run <= 1'b1;
      tick(12);
      apb(0, `TCMC_OFF_SC, 32'h0);
      chk("match flag", {24'h0, f, sc[6:0]}, rd);
      chk("pin", {30'h0, p}, {30'h0, chan_pin_oe, chan_pin_oe & chan_pin_out});
   endtask
   task automatic t_compare;
      arm(8'h18, 16'h0, 1'b1, 2'h2);
      arm(8'h14, 16'h0, 1'b1, 2'h3);
      arm(8'h1C, 16'h0, 1'b1, 2'h3);
      arm(8'h10, 16'h0, 1'b1, 2'h0);
      arm(8'h28, 16'h0, 1'b1, 2'h2);
      arm(8'h38, 16'h1, 1'b0, 2'h2);
      arm(8'h24, 16'h0, 1'b1, 2'h3);
      apb(1, `TCMC_OFF_GCTRL, 32'h1);
      arm(8'h08, 16'h0, 1'b1, 2'h2);
      chk("center", 32'h1, {31'h0, center_align_select});
      apb(1, `TCMC_OFF_GCTRL, 32'h0);
   endtask
   initial
   begin
      err_total = 0;
      compares = 0;
      {presetn, psel, penable, pwrite, run, lvl} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      modulo_value = 16'h0;
      tick(10);
      presetn <= 1'b1;
      tick(1);
      t_reset();
      t_capture();
      t_clear();
      t_compare();
      complete_run();
   end
endmodule
`default_nettype wire
